/* hw/cis_defs.svh */
// Constants for the compressor interlock stage supervisor
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH
`define CIS_CLK_HZ 100000000
`define CIS_DEB_MS 20
`define CIS_DEB_CYC ((`CIS_CLK_HZ / 1000) * `CIS_DEB_MS)
`define CIS_SEC_CYC (`CIS_CLK_HZ)
`define CIS_LOCKOUT_MIN 5
`define CIS_LOCKOUT_SEC (`CIS_LOCKOUT_MIN * 60)
`define CIS_REFR_MAX_MIN 300
`define CIS_FB_CHECKS 3
`define CIS_RETRY_SEC 60
`define CIS_FB_AUX 2'h0
`define CIS_FB_FAULT 2'h1
`define CIS_FB_CHAIN 2'h2
`define CIS_MAN_AUTO 2'h0
`define CIS_MAN_ON 2'h1
`define CIS_MAN_OFF 2'h2
`define CIS_ASSIGN_NONE 2'h0
`define CIS_ASSIGN_C1 2'h1
`define CIS_ASSIGN_C2 2'h2
`endif

/* hw/cis_pkg.sv */
// Types for the compressor interlock stage supervisor
package cis_pkg;
  typedef enum logic [1:0] {
    CIS_M_OFF = 2'b00,
    CIS_M_WAIT = 2'b01,
    CIS_M_RUN = 2'b10,
    CIS_M_BLOCK = 2'b11
  } cis_motor_st_t;
endpackage

/* hw/cis_tick_if.sv */
// Time base strobes shared between supervisor parts
`timescale 1ns/1ps
interface cis_tick_if;
  logic sec;
  logic min;
  modport src (output sec, output min);
  modport dst (input sec, input min);
endinterface

/* hw/cis_debounce.sv */
// Debouncer for a group of mains-level inputs
`timescale 1ns/1ps
`include "cis_defs.svh"
module cis_debounce #(
  parameter int W = 8,
  parameter int CYC = `CIS_DEB_CYC,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  localparam int CW = $clog2(CYC + 1);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [CW-1:0] cnt_q [W];

  // Two-stage synchroniser
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // Accept a level once stable for the filter time
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      clean <= INIT;
      for (int i = 0; i < W; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == clean[i])
          cnt_q[i] <= '0;
        else if (cnt_q[i] == CW'(CYC - 1))
        begin
          clean[i] <= s2_q[i];
          cnt_q[i] <= '0;
        end
        else
          cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end
endmodule

/* hw/cis_timebase.sv */
// Second and minute strobes from the system clock
`timescale 1ns/1ps
`include "cis_defs.svh"
module cis_timebase #(
  parameter int SEC_CYC = `CIS_SEC_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Strobes
  cis_tick_if.src tick
);
  localparam int CW = $clog2(SEC_CYC + 1);
  logic [CW-1:0] div_q;
  logic [5:0] sec_q;

  // Divider to one pulse per second and per minute
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      div_q <= '0;
      sec_q <= '0;
      tick.sec <= 1'b0;
      tick.min <= 1'b0;
    end
    else
    begin
      tick.sec <= 1'b0;
      tick.min <= 1'b0;
      if (div_q == CW'(SEC_CYC - 1))
      begin
        div_q <= '0;
        tick.sec <= 1'b1;
        if (sec_q == 6'h3b)
        begin
          sec_q <= '0;
          tick.min <= 1'b1;
        end
        else
          sec_q <= sec_q + 6'h01;
      end
      else
        div_q <= div_q + 1'b1;
    end
  end
endmodule

/* hw/cis_supervisor.sv */
// Compressor and fan interlock supervisor for two compounds
`timescale 1ns/1ps
`include "cis_defs.svh"
// How it works
// RULE_01 - Rapid shutdown stops compressors, pressure control stays
// RULE_02 - Suction limit drop stops compound compressors immediately
// RULE_03 - High-pressure trip stops compound compressors
// RULE_04 - Refrigerant low: delay, alarm, optional shutdown
// RULE_05 - Refrigerant low at start alarms at once
// RULE_06 - Emergency stop kills all, suppresses some alarms
// RULE_07 - Phase loss stops every compressor and fan
// RULE_08 - Night input forces night mode on units
// RULE_09 - Anti-frost drop stops compound and alarms
// RULE_10 - External lock stops compound without alarm
// RULE_11 - Stage and runtime only with valid feedback
// RULE_12 - Three selectable feedback modes
// RULE_13 - Report only first fault of safety chain
// RULE_14 - Missing feedback: start next, retry failed
// RULE_15 - Chain feedback alarm after three checks
// RULE_16 - Manual on, off, auto per motor
// RULE_17 - Runtime counter per compressor and fan
// RULE_18 - Minimum stop time before restart
// RULE_19 - Fault lockout, default five minutes
// RULE_20 - Daily start count, moved over at midnight
// RULE_21 - Fault actions only reach assigned units
// RULE_22 - Inputs synchronised and debounced; motor feedback, fault and chain inputs are used unfiltered
module cis_supervisor #(
  parameter int NC = 4,
  parameter int NF = 4,
  parameter int NU = 8,
  parameter int CHW = 3,
  parameter int SEC_CYC = `CIS_SEC_CYC,
  parameter int DEB_CYC = `CIS_DEB_CYC,
  parameter int LOCK_SEC = `CIS_LOCKOUT_SEC,
  parameter int RETRY_SEC = `CIS_RETRY_SEC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Per-compound safety inputs, bit 0 compound 1
  input wire logic [1:0] rapid_stop_in,
  input wire logic [1:0] suction_ok_in,
  input wire logic [1:0] hp_ok_in,
  input wire logic [1:0] refr_ok_in,
  input wire logic [1:0] frost_ok_in,
  input wire logic [1:0] lock_in,
  // Plant-wide inputs
  input wire logic estop_ok_in,
  input wire logic phase_ok_in,
  input wire logic night_in,
  // Motor feedback and faults; compressor i belongs to compound i/(NC/2)
  input wire logic [NC-1:0] comp_aux_in,
  input wire logic [NC-1:0] comp_fault_in,
  input wire logic [NC*CHW-1:0] comp_chain_in,
  input wire logic [NF-1:0] fan_aux_in,
  // Demand and configuration
  input wire logic [NC-1:0] comp_demand,
  input wire logic [NF-1:0] fan_demand,
  input wire logic [1:0] fb_mode,
  input wire logic [2*NC-1:0] comp_manual,
  input wire logic [2*NF-1:0] fan_manual,
  input wire logic [8:0] refr_delay_min,
  input wire logic [1:0] refr_shutdown_en,
  input wire logic [15:0] op_delay_sec,
  input wire logic [15:0] min_stop_sec,
  input wire logic [15:0] lockout_sec,
  input wire logic lockout_wr,
  input wire logic day_rollover,
  input wire logic [2*NU-1:0] unit_assign,
  // Relays
  output logic [NC-1:0] comp_relay,
  output logic [NF-1:0] fan_relay,
  output logic [1:0] hp_ctrl_en,
  // Alarms and status
  output logic [1:0] refr_alarm,
  output logic [1:0] frost_alarm,
  output logic [NC-1:0] fb_alarm,
  output logic [NC*CHW-1:0] chain_fault_report,
  output logic alarm_suppress,
  output logic [NC-1:0] comp_running,
  output logic [NU-1:0] unit_night,
  output logic [NU-1:0] unit_fault_act,
  output logic [31:0] comp_runtime [NC],
  output logic [31:0] fan_runtime [NF],
  output logic [15:0] starts_today,
  output logic [15:0] starts_yesterday
);
  localparam int NM = NC + NF;
  localparam int DW = 12;

  cis_tick_if tick ();

  logic [DW-1:0] d_raw;
  logic [DW-1:0] d_cln;
  logic [1:0] rapid_stop;
  logic [1:0] suction_ok;
  logic [1:0] hp_ok;
  logic [1:0] refr_ok;
  logic [1:0] frost_ok;
  logic [1:0] lock;
  logic estop_ok;
  logic phase_ok;
  logic [1:0] cmp_stop;
  logic plant_stop;
  logic [8:0] refr_cnt_q [2];
  logic start_q;
  logic [15:0] lock_time_q;
  logic [NM-1:0] feedback;
  logic [NM-1:0] fault;
  logic [NM-1:0] permit;
  logic [NM-1:0] want;
  logic [NM-1:0] relay_q;
  logic [NM-1:0] fb_fail;
  logic [NC-1:0] spare_req;
  logic [1:0] miss_q [NC];
  cis_pkg::cis_motor_st_t st_q [NM];
  logic [15:0] tmr_q [NM];
  logic [NM-1:0] retry_q;
  logic [31:0] run_q [NM];

  // Compound index of a compressor
  function automatic int comp_of(input int i);
    comp_of = (i < NC / 2) ? 0 : 1;
  endfunction

  // First open contact of a chain, one-hot
  function automatic logic [CHW-1:0] first_open(input logic [CHW-1:0] ok);
    first_open = '0;
    for (int k = CHW - 1; k >= 0; k--)
      if (!ok[k])
        first_open = '0 | (CHW'(1) << k);
  endfunction

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  assign d_raw = {rapid_stop_in, suction_ok_in, hp_ok_in, refr_ok_in, frost_ok_in, lock_in};
  cis_debounce #(.W(DW), .CYC(DEB_CYC), .INIT(12'h3fc)) u_deb_cmp ( // RULE_22
    .clock(clock), .rst(rst), .raw(d_raw), .clean(d_cln));
  assign {rapid_stop, suction_ok, hp_ok, refr_ok, frost_ok, lock} = d_cln;

  logic [2:0] p_cln;
  cis_debounce #(.W(3), .CYC(DEB_CYC), .INIT(3'h6)) u_deb_plant ( // RULE_22
    .clock(clock), .rst(rst), .raw({estop_ok_in, phase_ok_in, night_in}), .clean(p_cln));
  assign estop_ok = p_cln[2];
  assign phase_ok = p_cln[1];

  cis_timebase #(.SEC_CYC(SEC_CYC)) u_tb (.clock(clock), .rst(rst), .tick(tick));

  // ----------------------------------------------------------------
  // Interlocks
  // ----------------------------------------------------------------
  assign plant_stop = !estop_ok || !phase_ok; // RULE_06 RULE_07
  assign alarm_suppress = !estop_ok; // RULE_06
  assign hp_ctrl_en = ~{2{plant_stop}}; // RULE_01
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      cmp_stop[c] = rapid_stop[c] // RULE_01
        || !suction_ok[c] // RULE_02
        || !hp_ok[c] // RULE_03
        || !frost_ok[c] // RULE_09
        || lock[c] // RULE_10
        || (refr_alarm[c] && refr_shutdown_en[c]) // RULE_04
        || plant_stop;
    end
  end

  // Refrigerant-low delay and alarm
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      start_q <= 1'b1;
      refr_alarm <= 2'h0;
      refr_cnt_q[0] <= '0;
      refr_cnt_q[1] <= '0;
    end
    else
    begin
      if (tick.sec)
        start_q <= 1'b0;
      for (int c = 0; c < 2; c++)
      begin
        if (refr_ok[c])
        begin
          refr_cnt_q[c] <= '0;
          refr_alarm[c] <= 1'b0;
        end
        else if (start_q)
          refr_alarm[c] <= 1'b1; // RULE_05
        else if (refr_cnt_q[c] >= refr_delay_min)
          refr_alarm[c] <= 1'b1; // RULE_04
        else if (tick.min)
          refr_cnt_q[c] <= refr_cnt_q[c] + 9'h001; // RULE_04
      end
    end
  end

  // Frost alarm, held off during emergency stop
  assign frost_alarm = ~frost_ok & ~{2{alarm_suppress}}; // RULE_09 RULE_06

  // Night command to every unit
  assign unit_night = {NU{p_cln[0]}}; // RULE_08

  // Fault actions go only to units of the stopped compound
  always_comb
  begin
    for (int u = 0; u < NU; u++)
      unit_fault_act[u] = (unit_assign[2*u +: 2] == `CIS_ASSIGN_C1 && cmp_stop[0] && !lock[0])
        || (unit_assign[2*u +: 2] == `CIS_ASSIGN_C2 && cmp_stop[1] && !lock[1]); // RULE_21
  end

  // ----------------------------------------------------------------
  // Feedback and chain faults
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NC; i++)
    begin
      chain_fault_report[i*CHW +: CHW] = first_open(comp_chain_in[i*CHW +: CHW]); // RULE_13
      unique case (fb_mode) // RULE_12
        `CIS_FB_AUX: feedback[i] = comp_aux_in[i];
        `CIS_FB_FAULT: feedback[i] = !comp_fault_in[i];
        default: feedback[i] = (&comp_chain_in[i*CHW +: CHW]) && !comp_fault_in[i];
      endcase
      fault[i] = comp_fault_in[i];
      permit[i] = !cmp_stop[comp_of(i)];
      unique case (comp_manual[2*i +: 2]) // RULE_16
        `CIS_MAN_ON: want[i] = 1'b1;
        `CIS_MAN_OFF: want[i] = 1'b0;
        default: want[i] = comp_demand[i] || spare_req[i];
      endcase
    end
    for (int f = 0; f < NF; f++)
    begin
      feedback[NC+f] = fan_aux_in[f];
      fault[NC+f] = 1'b0;
      permit[NC+f] = !plant_stop;
      unique case (fan_manual[2*f +: 2]) // RULE_16
        `CIS_MAN_ON: want[NC+f] = 1'b1;
        `CIS_MAN_OFF: want[NC+f] = 1'b0;
        default: want[NC+f] = fan_demand[f];
      endcase
    end
  end

  // A failed compressor hands demand to every other compressor without demand in its compound
  always_comb
  begin
    for (int i = 0; i < NC; i++)
    begin
      spare_req[i] = 1'b0;
      for (int j = 0; j < NC; j++)
        if (j != i && comp_of(j) == comp_of(i) && fb_fail[j] && comp_demand[j] && !comp_demand[i])
          spare_req[i] = 1'b1; // RULE_14
    end
  end

  // Lockout time, changed only through the service write
  always_ff @(posedge clock)
  begin
    if (rst)
      lock_time_q <= 16'(LOCK_SEC);
    else if (lockout_wr)
      lock_time_q <= lockout_sec; // RULE_19
  end

  // ----------------------------------------------------------------
  // Motor sequencers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      relay_q <= '0;
      fb_fail <= '0;
      retry_q <= '0;
      for (int m = 0; m < NM; m++)
      begin
        st_q[m] <= cis_pkg::CIS_M_OFF;
        tmr_q[m] <= '0;
      end
    end
    else
    begin
      for (int m = 0; m < NM; m++)
      begin
        if (tick.sec && tmr_q[m] != 16'h0000)
          tmr_q[m] <= tmr_q[m] - 16'h0001;
        if (tick.sec && fb_fail[m] && !retry_q[m])
          retry_q[m] <= 1'b1;
        unique case (st_q[m])
          cis_pkg::CIS_M_OFF:
            if (want[m] && permit[m] && tmr_q[m] == 16'h0000 && !fault[m] && (!fb_fail[m] || retry_q[m]))
            begin
              relay_q[m] <= 1'b1;
              retry_q[m] <= 1'b0;
              tmr_q[m] <= op_delay_sec;
              st_q[m] <= cis_pkg::CIS_M_WAIT;
            end
          cis_pkg::CIS_M_WAIT:
            if (!want[m] || !permit[m] || fault[m])
            begin
              relay_q[m] <= 1'b0;
              tmr_q[m] <= fault[m] ? lock_time_q : min_stop_sec;
              st_q[m] <= fault[m] ? cis_pkg::CIS_M_BLOCK : cis_pkg::CIS_M_OFF;
            end
            else if (feedback[m])
            begin
              fb_fail[m] <= 1'b0;
              st_q[m] <= cis_pkg::CIS_M_RUN;
            end
            else if (tmr_q[m] == 16'h0000)
            begin
              relay_q[m] <= 1'b0; // RULE_14
              fb_fail[m] <= 1'b1;
              tmr_q[m] <= 16'(RETRY_SEC);
              st_q[m] <= cis_pkg::CIS_M_OFF;
            end
          cis_pkg::CIS_M_RUN:
            if (fault[m])
            begin
              relay_q[m] <= 1'b0;
              tmr_q[m] <= lock_time_q; // RULE_19
              st_q[m] <= cis_pkg::CIS_M_BLOCK;
            end
            else if (!want[m] || !permit[m] || !feedback[m])
            begin
              relay_q[m] <= 1'b0;
              tmr_q[m] <= min_stop_sec; // RULE_18
              st_q[m] <= cis_pkg::CIS_M_OFF;
            end
          cis_pkg::CIS_M_BLOCK:
            if (tmr_q[m] == 16'h0000)
            begin
              tmr_q[m] <= min_stop_sec; // RULE_18
              st_q[m] <= cis_pkg::CIS_M_OFF;
            end
        endcase
      end
    end
  end

  // Relays drop at once on their interlocks: compressors on compound stops, fans only on plant-wide stops
  always_comb
  begin
    for (int m = 0; m < NM; m++)
    begin
      if (m < NC)
        comp_relay[m] = relay_q[m] && permit[m]; // RULE_01 RULE_02 RULE_03
      else
        fan_relay[m-NC] = relay_q[m] && permit[m]; // RULE_06 RULE_07
    end
  end

  // Chain feedback miss counted on successive checks
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      fb_alarm <= '0;
      for (int i = 0; i < NC; i++)
        miss_q[i] <= 2'h0;
    end
    else if (tick.sec)
    begin
      for (int i = 0; i < NC; i++)
      begin
        if (!want[i] || feedback[i] || fb_mode != `CIS_FB_CHAIN)
        begin
          miss_q[i] <= 2'h0;
          fb_alarm[i] <= 1'b0;
        end
        else if (miss_q[i] == 2'(`CIS_FB_CHECKS - 1))
          fb_alarm[i] <= !alarm_suppress; // RULE_15
        else
          miss_q[i] <= miss_q[i] + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Runtime and start statistics
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int m = 0; m < NM; m++)
        run_q[m] <= '0;
    end
    else if (tick.sec)
    begin
      for (int m = 0; m < NM; m++)
        if (st_q[m] == cis_pkg::CIS_M_RUN && feedback[m])
          run_q[m] <= run_q[m] + 32'h00000001; // RULE_11 RULE_17
    end
  end

  always_comb
  begin
    for (int i = 0; i < NC; i++)
    begin
      comp_running[i] = st_q[i] == cis_pkg::CIS_M_RUN && feedback[i]; // RULE_11
      comp_runtime[i] = run_q[i];
    end
    for (int f = 0; f < NF; f++)
      fan_runtime[f] = run_q[NC+f];
  end

  // Count confirmed compressor starts per day
  logic [NC-1:0] run_prev_q;
  logic [15:0] new_starts;
  always_comb
  begin
    new_starts = 16'h0000;
    for (int i = 0; i < NC; i++)
      if (comp_running[i] && !run_prev_q[i])
        new_starts = new_starts + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      run_prev_q <= '0;
      starts_today <= 16'h0000;
      starts_yesterday <= 16'h0000;
    end
    else
    begin
      run_prev_q <= comp_running;
      if (day_rollover)
      begin
        starts_yesterday <= starts_today + new_starts; // RULE_20
        starts_today <= 16'h0000;
      end
      else
        starts_today <= starts_today + new_starts; // RULE_20
    end
  end
endmodule

/* test/cis_monitor.sv */
// Concurrent checks on the supervisor top ports
`timescale 1ns/1ps
module cis_monitor #(
  parameter int NC = 4,
  parameter int NF = 4,
  parameter int NU = 8,
  parameter int CHW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched inputs
  input wire logic [1:0] rapid_stop_in,
  input wire logic [1:0] suction_ok_in,
  input wire logic [1:0] hp_ok_in,
  input wire logic [1:0] frost_ok_in,
  input wire logic [1:0] lock_in,
  input wire logic estop_ok_in,
  input wire logic phase_ok_in,
  input wire logic night_in,
  input wire logic [NC*CHW-1:0] comp_chain_in,
  input wire logic [15:0] min_stop_sec,
  input wire logic day_rollover,
  // Watched outputs
  input wire logic [NC-1:0] comp_relay,
  input wire logic [NF-1:0] fan_relay,
  input wire logic [1:0] hp_ctrl_en,
  input wire logic [1:0] frost_alarm,
  input wire logic alarm_suppress,
  input wire logic [NC*CHW-1:0] chain_fault_report,
  input wire logic [NC-1:0] comp_running,
  input wire logic [NU-1:0] unit_night,
  input wire logic [15:0] starts_today,
  input wire logic [15:0] starts_yesterday
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Inputs held 8 cycles are past the filter
  AST_RAPID_STOP:
    assert property (rapid_stop_in[0] [*8] |-> comp_relay[NC/2-1:0] == '0) else $error("rapid stop left compressor on");
  AST_HP_CTRL_KEPT:
    assert property ((estop_ok_in && phase_ok_in) [*8] |-> hp_ctrl_en == 2'h3) else $error("pressure control dropped");
  AST_SUCTION:
    assert property ((!suction_ok_in[0]) [*8] |-> comp_relay[NC/2-1:0] == '0) else $error("suction trip ignored");
  AST_HIGH_PRESS:
    assert property ((!hp_ok_in[0]) [*8] |-> comp_relay[NC/2-1:0] == '0) else $error("high pressure trip ignored");
  AST_ESTOP:
    assert property ((!estop_ok_in) [*8] |-> comp_relay == '0 && fan_relay == '0 && alarm_suppress)
    else $error("emergency stop ignored");
  AST_PHASE:
    assert property ((!phase_ok_in) [*8] |-> comp_relay == '0 && fan_relay == '0 && hp_ctrl_en == 2'h0)
    else $error("phase loss ignored");
  AST_NIGHT:
    assert property (night_in [*8] |-> unit_night == '1) else $error("night not forwarded");
  AST_FROST:
    assert property ((!frost_ok_in[0]) [*8] |-> comp_relay[NC/2-1:0] == '0 && frost_alarm[0])
    else $error("frost trip ignored");
  AST_LOCK:
    assert property ((lock_in[0] && frost_ok_in[0]) [*8] |-> comp_relay[NC/2-1:0] == '0 && !frost_alarm[0])
    else $error("lock misbehaved");
  AST_CHAIN_FIRST:
    assert property (chain_fault_report[1] |-> comp_chain_in[0] && !comp_chain_in[1]) else $error("downstream fault shown");
  AST_MIN_STOP:
    assert property ($fell(comp_relay[0]) && min_stop_sec != 16'h0 |=> !comp_relay[0] [*8])
    else $error("restart inside stop time");
  AST_ROLLOVER:
    assert property (day_rollover |=> starts_yesterday == $past(starts_today) && starts_today == 16'h0)
    else $error("start count not moved");
  // Main scenarios reached
  COV_RUN: cover property (comp_running[0]);
  COV_FROST: cover property (frost_alarm[0]);
  COV_DAY: cover property (day_rollover);
endmodule

/* test/cis_plant_model.sv */
// Relay, contact and safety chain model of the plant
`timescale 1ns/1ps
module cis_plant_model (
  // Clock
  input wire logic clock,
  // Relay coils
  input wire logic [3:0] comp_relay,
  input wire logic [3:0] fan_relay,
  // Behaviour controls
  input wire logic slow,
  input wire logic [3:0] fail_mask,
  input wire logic [11:0] chain_open,
  // Contacts back to the supervisor
  output logic [3:0] comp_aux_in,
  output logic [3:0] fan_aux_in,
  output logic [11:0] comp_chain_in
);
  logic [3:0] c_q [4];
  logic [3:0] f_q [4];
  // Contact pull-in delay line
  always_ff @(posedge clock)
  begin
    c_q[0] <= comp_relay;
    f_q[0] <= fan_relay;
    for (int i = 1; i < 4; i++)
    begin
      c_q[i] <= c_q[i-1];
      f_q[i] <= f_q[i-1];
    end
  end
  // Dead motors never close their contact
  assign comp_aux_in = (slow ? c_q[3] : c_q[0]) & ~fail_mask;
  assign fan_aux_in = slow ? f_q[3] : f_q[0];
  // Chain closed unless opened on purpose
  assign comp_chain_in = ~chain_open;
endmodule

/* test/compressor_interlock_stage_supervisor_bench.sv */
// Self-checking bench for the interlock supervisor
`timescale 1ns/1ps
module compressor_interlock_stage_supervisor_bench;
  logic clock, rst, estop_ok_in, phase_ok_in, night_in, lockout_wr, day_rollover, slow, alarm_suppress;
  logic [1:0] rapid_stop_in, suction_ok_in, hp_ok_in, refr_ok_in, frost_ok_in, lock_in, fb_mode, refr_shutdown_en;
  logic [1:0] hp_ctrl_en, refr_alarm, frost_alarm;
  logic [3:0] comp_aux_in, comp_fault_in, fan_aux_in, comp_demand, fan_demand, fail_mask;
  logic [3:0] comp_relay, fan_relay, fb_alarm, comp_running;
  logic [11:0] comp_chain_in, chain_open, chain_fault_report;
  logic [7:0] comp_manual, fan_manual, unit_night, unit_fault_act;
  logic [8:0] refr_delay_min;
  logic [15:0] op_delay_sec, min_stop_sec, lockout_sec, unit_assign, starts_today, starts_yesterday;
  logic [31:0] comp_runtime [4];
  logic [31:0] fan_runtime [4];
  int mismatches, n_compared;
  // Design under test with short time base
  cis_supervisor #(.SEC_CYC(10), .DEB_CYC(4)) cis_supervisor_i (.*);
  // Far side of the relays
  cis_plant_model cis_plant_model_i (.clock(clock), .comp_relay(comp_relay), .fan_relay(fan_relay), .slow(slow),
    .fail_mask(fail_mask), .chain_open(chain_open), .comp_aux_in(comp_aux_in), .fan_aux_in(fan_aux_in),
    .comp_chain_in(comp_chain_in));
  // Clock at 100 MHz
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Cycles, then sample once settled
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Bounded wait for a compressor relay level
  task automatic wait_on(input int i, input logic v, input int lim);
    int k;
    k = 0;
    while (comp_relay[i] !== v && k < lim)
    begin
      tick(1);
      k++;
    end
    if (k >= lim)
    begin
      mismatches++;
      $display("[ERR] relay %0d expected %b seen %b", i, v, comp_relay[i]);
      give_verdict();
    end
  endtask
  // Start, daily count and delayed refrigerant shutdown
  task automatic s_refr();
    @(posedge clock);
    refr_ok_in <= 2'h3;
    comp_demand <= 4'h1;
    wait_on(0, 1'b1, 20);
    tick(3);
    chk("running", comp_running[0], 1'b1);
    @(posedge clock);
    day_rollover <= 1'b1;
    @(posedge clock);
    day_rollover <= 1'b0;
    tick(1);
    chk("yesterday", starts_yesterday, 16'h1);
    chk("today", starts_today, 16'h0);
    refr_ok_in <= 2'h2;
    tick(590);
    chk("refr early", {refr_alarm[0], comp_relay[0]}, 2'h1);
    wait_on(0, 1'b0, 1300);
    chk("refr alarm", refr_alarm[0], 1'b1);
    chk("runtimes", {comp_runtime[0] != 0, fan_runtime[0] == 0}, 2'h3);
    refr_ok_in <= 2'h3;
    refr_shutdown_en <= 2'h0;
    comp_demand <= 4'h0;
  endtask
  // Restart blocked for the stop time
  task automatic s_minstop();
    slow <= 1'b1;
    tick(30);
    comp_demand <= 4'h1;
    wait_on(0, 1'b1, 20);
    tick(8);
    comp_demand <= 4'h0;
    tick(2);
    comp_demand <= 4'h1;
    tick(15);
    chk("stop hold", comp_relay[0], 1'b0);
    wait_on(0, 1'b1, 30);
    slow <= 1'b0;
  endtask
  // Compound one interlocks, compound two keeps running
  task automatic s_interlock();
    comp_demand <= 4'h5;
    wait_on(2, 1'b1, 40);
    for (int k = 0; k < 5; k++)
    begin
      wait_on(0, 1'b1, 60);
      @(posedge clock);
      case (k)
        0: rapid_stop_in <= 2'h1;
        1: suction_ok_in <= 2'h2;
        2: hp_ok_in <= 2'h2;
        3: frost_ok_in <= 2'h2;
        default: lock_in <= 2'h1;
      endcase
      tick(10);
      chk("trip", {comp_relay[0], comp_relay[2], hp_ctrl_en}, 4'h7);
      chk("frost alarm", frost_alarm[0], k == 3);
      if (k >= 3)
        chk("units", unit_fault_act[2:0], {2'h0, k == 3});
      {rapid_stop_in, lock_in} <= 4'h0;
      {suction_ok_in, hp_ok_in, frost_ok_in} <= 6'h3f;
    end
  endtask
  // Plant-wide stops and night forwarding
  task automatic s_plant();
    fan_demand <= 4'h1;
    tick(10);
    for (int k = 0; k < 2; k++)
    begin
      wait_on(0, 1'b1, 60);
      chk("fan on", fan_relay[0], 1'b1);
      @(posedge clock);
      {estop_ok_in, phase_ok_in} <= k ? 2'h2 : 2'h1;
      tick(10);
      chk("all off", {comp_relay, fan_relay, hp_ctrl_en}, 10'h0);
      chk("suppress", alarm_suppress, k == 0);
      {estop_ok_in, phase_ok_in} <= 2'h3;
    end
    night_in <= 1'b1;
    tick(10);
    chk("night", unit_night, 8'hff);
    night_in <= 1'b0;
    fan_demand <= 4'h0;
  endtask
  // Dead motor handed over to the spare
  task automatic s_feedback();
    fail_mask <= 4'h2;
    comp_demand <= 4'h2;
    wait_on(1, 1'b1, 60);
    wait_on(0, 1'b1, 60);
    chk("dead motor", {comp_running[1], comp_relay[1]}, 2'h0);
    fail_mask <= 4'h0;
    comp_demand <= 4'h0;
  endtask
  // Chain reporting, chain alarm and fault lockout
  task automatic s_chain();
    fb_mode <= 2'h2;
    comp_demand <= 4'h1;
    wait_on(0, 1'b1, 60);
    chain_open <= 12'h006;
    tick(2);
    chk("chain first", chain_fault_report[2:0], 3'h2);
    chain_open <= 12'h007;
    tick(2);
    chk("chain top", chain_fault_report[2:0], 3'h1);
    tick(45);
    chk("chain alarm", fb_alarm[0], 1'b1);
    chain_open <= 12'h000;
    fb_mode <= 2'h1;
    fail_mask <= 4'hf;
    wait_on(0, 1'b1, 700);
    tick(3);
    chk("assumed", comp_running[0], 1'b1);
    comp_fault_in <= 4'h1;
    tick(2);
    comp_fault_in <= 4'h0;
    tick(900);
    chk("lockout", comp_relay[0], 1'b0);
    wait_on(0, 1'b1, 400);
    fail_mask <= 4'h0;
    fb_mode <= 2'h0;
  endtask
  // Manual on and off override demand
  task automatic s_manual();
    comp_manual <= 8'h42;
    fan_manual <= 8'h04;
    tick(30);
    chk("manual", {comp_relay, fan_relay}, 8'h82);
  endtask
  initial
  begin
    {estop_ok_in, phase_ok_in, night_in, lockout_wr, day_rollover, slow} = 6'h30;
    {rapid_stop_in, lock_in, fb_mode} = 6'h0;
    {suction_ok_in, hp_ok_in, frost_ok_in} = 6'h3f;
    refr_ok_in = 2'h2;
    refr_shutdown_en = 2'h1;
    refr_delay_min = 9'h2;
    {comp_fault_in, comp_demand, fan_demand, fail_mask} = 16'h0;
    {chain_open, comp_manual, fan_manual} = 28'h0;
    op_delay_sec = 16'h1;
    min_stop_sec = 16'h2;
    lockout_sec = 16'h64;
    unit_assign = 16'h0009;
    mismatches = 0;
    n_compared = 0;
    rst = 1'b1;
    tick(4);
    rst <= 1'b0;
    lockout_wr <= 1'b1;
    tick(8);
    lockout_wr <= 1'b0;
    chk("start alarm", refr_alarm, 2'h1);
    s_refr();
    s_minstop();
    s_interlock();
    s_plant();
    s_feedback();
    s_chain();
    s_manual();
    give_verdict();
  end
endmodule
bind cis_supervisor cis_monitor #(.NC(NC), .NF(NF), .NU(NU), .CHW(CHW)) cis_monitor_i (.*);
